// >>> pkg/rtc_pkg.sv
// What this block does
// - Link starts only on start with key 1
// - Good start: orange, green, then green flashing
// - Start with active command: orange, then off or red
// - Active command: any control off rest, stop
// - Slow key halves sticks 2,3,4,7 in movement
// - Mode selector enables only that mode's functions, except the held gear and the aux outputs, which still drive in every mode
// - Drill entry with push/pull off: all off
// - Stick 1 beats stick 5
// - Stick 8 beats stick 5
// - Stick 7 beats stick 6
// - Head 1 auto latch sequence, knob speed
// - Stick 8 or leaving drill cancels head 1
// - Head 2 auto latch sequence
// - Head 2 speed eight levels, up and down
// - Head 2 level kept across power-off
// - Stick 7 or leaving drill cancels head 2
// - Push scaled by knob, pull at maximum
// - Stick 1 forces maximum force and speed
// - Pump and percussion toggle, clear leaving drill
// - Gear steps off, first, second on forward
// - Gear back steps back, blocks charger, aux
package rtc_pkg;
   // clock and timing figures
   localparam int CLK_HZ = 100_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int ORANGE_OK_MS = 500;
   localparam int GREEN_MS = 1000;
   localparam int ALARM_MS = 1000;
   localparam int FLASH_HALF_MS = 500;
   localparam int FAST_HALF_MS = 100;
   localparam int DEBOUNCE_MS = 10;
   localparam int ORANGE_OK_CYC = ORANGE_OK_MS * CYC_PER_MS;
   localparam int GREEN_CYC = GREEN_MS * CYC_PER_MS;
   localparam int ALARM_CYC = ALARM_MS * CYC_PER_MS;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
   localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
   // stick layout, limits and reset values
   localparam int NSTICK = 8;
   localparam int STICK_W = 8;
   localparam logic [7:0] FORCE_MAX = 8'hFF;
   localparam logic [2:0] LEVEL_MAX = 3'h7;
   localparam logic [1:0] GEAR_LAST = 2'h2;
   localparam logic [1:0] GEAR_RST = 2'h0;
   localparam logic [7:0] SLOW_MASK = 8'h4E;
   localparam logic [7:0] MOVE_MASK_DEF = 8'h4E;
   localparam logic [7:0] PLACE_MASK_DEF = 8'h3F;
   localparam logic [7:0] DRILL_MASK_DEF = 8'hF1;
   // mode selector contacts, one hot
   typedef enum logic [2:0] {
      MODE_MOVE = 3'b001,
      MODE_PLACE = 3'b010,
      MODE_DRILL = 3'b100
   } rtc_mode_t;
   // pulse type controls, debounced
   typedef struct packed {
      logic start;
      logic auto_rot;
      logic h2_up;
      logic h2_down;
      logic gear_fwd;
      logic gear_back;
      logic pump;
      logic perc;
   } rtc_btn_t;
   // level type controls
   typedef struct packed {
      logic key_pos1;
      logic key_slow;
      logic estop;
      logic push_pull_up;
      logic push_pull_down;
      logic gear_enable;
      logic alt_gear_enable;
      logic aux_a;
      logic aux_b;
      logic [2:0] mode_selector;
   } rtc_sw_t;
   typedef struct packed {
      logic red;
      logic green;
   } rtc_lamp_t;
   typedef enum logic [5:0] {
      LS_IDLE = 6'b000001,
      LS_ORANGE = 6'b000010,
      LS_GREEN = 6'b000100,
      LS_LINK = 6'b001000,
      LS_ALARM = 6'b010000,
      LS_RED = 6'b100000
   } rtc_lstate_t;
   typedef enum logic [3:0] {
      AU_IDLE = 4'b0001,
      AU_PRESS = 4'b0010,
      AU_REL = 4'b0100,
      AU_ON = 4'b1000
   } rtc_auto_t;
endpackage

// >>> hdl/rtc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl import rtc_pkg::*; #(
   parameter int T_ORANGE = ORANGE_OK_CYC,
   parameter int T_GREEN = GREEN_CYC,
   parameter int T_ALARM = ALARM_CYC,
   parameter int T_FLASH = FLASH_HALF_CYC,
   parameter int T_FAST = FAST_HALF_CYC,
   parameter int T_DEB = DEBOUNCE_CYC,
   parameter logic [7:0] MOVE_MASK = MOVE_MASK_DEF,
   parameter logic [7:0] PLACE_MASK = PLACE_MASK_DEF,
   parameter logic [7:0] DRILL_MASK = DRILL_MASK_DEF,
   parameter bit USE_ALT_GEAR = 1'b0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // operator controls, asynchronous pins
   input wire rtc_btn_t btn_raw,
   input wire rtc_sw_t sw_raw,
   input wire logic [NSTICK-1:0][STICK_W-1:0] stick_raw,
   input wire logic [7:0] thrust_force_knob,
   input wire logic [7:0] head1_speed_knob,
   // head 2 level held in non-volatile store
   input wire logic [2:0] head2_level_restore,
   // lamps and link
   output logic link_active,
   output rtc_lamp_t battery_status_lamp,
   output logic option_check_lamp,
   // commands to the receiver
   output logic [NSTICK-1:0][STICK_W-1:0] stick_cmd,
   output logic head1_auto,
   output logic [7:0] head1_speed_cmd,
   output logic head2_auto,
   output logic [2:0] head2_level,
   output logic push_cmd,
   output logic pull_cmd,
   output logic [7:0] force_cmd,
   output logic head_speed_max,
   output logic pump_on,
   output logic percussion_on,
   output logic gear_output_a,
   output logic gear_output_b,
   output logic aux_a_cmd,
   output logic aux_b_cmd,
   output logic charger_block
);
   localparam int SYNC_W = 8 + $bits(rtc_sw_t) + NSTICK * STICK_W + 16;
   localparam int DEB_W = $clog2(T_DEB + 1);
   localparam logic [31:0] LD_ORANGE = 32'(T_ORANGE - 1);
   localparam logic [31:0] LD_GREEN = 32'(T_GREEN - 1);
   localparam logic [31:0] LD_ALARM = 32'(T_ALARM - 1);
   localparam logic [31:0] LD_FLASH = 32'(T_FLASH - 1);
   localparam logic [31:0] LD_FAST = 32'(T_FAST - 1);

   function automatic logic [2:0] sat_step(input logic [2:0] v,
      input logic up, input logic dn, input logic [2:0] top);
      if (up && v != top) return v + 3'h1;
      if (dn && v != 3'h0) return v - 3'h1;
      return v;
   endfunction

   // one latch sequence serves both heads
   function automatic rtc_auto_t auto_step(input rtc_auto_t s,
      input logic defl, input logic hold, input logic press,
      input logic en);
      if (!en) return AU_IDLE;
      case (s)
         AU_IDLE: return (defl && press) ? AU_PRESS : AU_IDLE;
         AU_PRESS: return !hold ? AU_IDLE : (!defl ? AU_REL : AU_PRESS);
         AU_REL: return defl ? AU_IDLE : (!hold ? AU_ON : AU_REL);
         AU_ON: return defl ? AU_IDLE : AU_ON;
         default: return AU_IDLE;
      endcase
   endfunction

   // two-stage synchroniser on every operator control pin
   logic [SYNC_W-1:0] sync1_reg, sync2_reg;
   always_ff @(posedge clk_sys) begin
      sync1_reg <= {btn_raw, sw_raw, stick_raw, thrust_force_knob,
                    head1_speed_knob};
      sync2_reg <= sync1_reg;
   end
   logic [7:0] btn_s;
   rtc_sw_t sw;
   logic [NSTICK-1:0][STICK_W-1:0] stick;
   logic [7:0] knob_t, knob_h;
   assign {btn_s, sw, stick, knob_t, knob_h} = sync2_reg;

   // debounce: a change must hold T_DEB cycles to be accepted
   logic [7:0] btn_db_v, btn_prev_reg;
   for (genvar i = 0; i < 8; i++) begin : g_deb
      logic [DEB_W-1:0] cnt_reg;
      logic db_reg;
      always_ff @(posedge clk_sys) begin
         if (srst || btn_s[i] == db_reg) begin
            cnt_reg <= '0;
            db_reg <= srst ? 1'b0 : db_reg;
         end else if (cnt_reg == DEB_W'(T_DEB - 1)) begin
            cnt_reg <= '0;
            db_reg <= btn_s[i];
         end else begin
            cnt_reg <= cnt_reg + DEB_W'(1);
         end
      end
      assign btn_db_v[i] = db_reg;
   end
   always_ff @(posedge clk_sys) begin
      btn_prev_reg <= srst ? 8'h00 : btn_db_v;
   end
   rtc_btn_t btn, rise;
   assign btn = rtc_btn_t'(btn_db_v);
   assign rise = rtc_btn_t'(btn_db_v & ~btn_prev_reg);

   // deflection and active-command detection
   logic [NSTICK-1:0] defl;
   for (genvar i = 0; i < NSTICK; i++) begin : g_defl
      assign defl[i] = stick[i] != '0;
   end
   wire active = |defl | sw.estop | sw.push_pull_up | sw.push_pull_down |
      sw.gear_enable | sw.alt_gear_enable | sw.aux_a | sw.aux_b |
      (|btn_db_v[6:0]);
   wire start_ok = sw.key_pos1 && rise.start;

   // start and lamp sequencer
   rtc_lstate_t st_reg, st_next;
   logic [31:0] tmr_reg, tmr_next;
   logic phase_reg;
   wire tmr_done = tmr_reg == 32'h0000_0000;
   always_comb begin
      st_next = st_reg;
      tmr_next = tmr_done ? tmr_reg : tmr_reg - 32'h0000_0001;
      case (st_reg)
         LS_IDLE: begin
            if (start_ok) begin
               st_next = active ? LS_ALARM : LS_ORANGE;
               tmr_next = active ? LD_ALARM : LD_ORANGE;
            end
         end
         LS_ORANGE: begin
            if (tmr_done) begin
               st_next = LS_GREEN;
               tmr_next = LD_GREEN;
            end
         end
         LS_GREEN: begin
            if (tmr_done) begin
               st_next = LS_LINK;
               tmr_next = LD_FLASH;
            end
         end
         LS_LINK: begin
            if (tmr_done) tmr_next = LD_FLASH;
         end
         LS_ALARM: begin
            // orange then off, or red while start stays held
            if (tmr_done) st_next = (btn.start && active) ? LS_RED : LS_IDLE;
         end
         LS_RED: begin
            if (!btn.start || !active) st_next = LS_IDLE;
         end
         default: st_next = LS_IDLE;
      endcase
      if (!sw.key_pos1) st_next = LS_IDLE;
   end
   always_ff @(posedge clk_sys) begin
      st_reg <= srst ? LS_IDLE : st_next;
      tmr_reg <= srst ? 32'h0000_0000 : tmr_next;
   end
   // green blink phase, one full flash per second
   always_ff @(posedge clk_sys) begin
      if (srst || st_reg != LS_LINK) phase_reg <= 1'b1;
      else if (tmr_done) phase_reg <= ~phase_reg;
   end
   // fast blink for the option check lamp
   logic [31:0] fast_reg;
   logic fast_ph_reg;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fast_reg <= 32'h0000_0000;
         fast_ph_reg <= 1'b0;
      end else begin
         fast_reg <= (fast_reg == 32'h0000_0000) ? LD_FAST
                     : fast_reg - 32'h0000_0001;
         fast_ph_reg <= fast_ph_reg ^ (fast_reg == 32'h0000_0000);
      end
   end

   // mode decode and drill-entry fault
   wire move = sw.mode_selector == MODE_MOVE;
   wire drill = sw.mode_selector == MODE_DRILL;
   wire [7:0] mode_mask = move ? MOVE_MASK
      : (sw.mode_selector == MODE_PLACE) ? PLACE_MASK
      : drill ? DRILL_MASK : 8'h00;
   wire pp_off = sw.push_pull_up | sw.push_pull_down;
   logic drill_prev_reg, fault_reg;
   // set wins: entry with selector off centre holds until centred or drill is left
   always_ff @(posedge clk_sys) begin
      drill_prev_reg <= srst ? 1'b0 : drill;
      if (srst) fault_reg <= 1'b0;
      else if (drill && !drill_prev_reg && pp_off) fault_reg <= 1'b1;
      else if (!pp_off || !drill) fault_reg <= 1'b0;
   end
   wire link = st_reg == LS_LINK;
   wire run = link && !fault_reg;
   wire drun = run && drill;

   // head automatic rotation latches
   rtc_auto_t au1_reg, au2_reg;
   always_ff @(posedge clk_sys) begin
      au1_reg <= srst ? AU_IDLE
         : auto_step(au1_reg, defl[7], btn.auto_rot, rise.auto_rot,
                     drun);
      au2_reg <= srst ? AU_IDLE
         : auto_step(au2_reg, defl[6], btn.auto_rot, rise.auto_rot,
                     drun);
   end

   // head 2 level restored once after reset, then stepped
   logic [2:0] level_reg;
   logic init_reg;
   always_ff @(posedge clk_sys) begin
      init_reg <= !srst;
      if (srst) level_reg <= 3'h0;
      else if (!init_reg) level_reg <= head2_level_restore;
      else if (drun)
         level_reg <= sat_step(level_reg, rise.h2_up, rise.h2_down,
                               LEVEL_MAX);
   end

   // gear stepper, blocks charger and aux while held
   wire gear_act = drun && (USE_ALT_GEAR ? sw.alt_gear_enable
                                         : sw.gear_enable);
   logic [1:0] gear_reg;
   wire [2:0] gear_step = sat_step({1'b0, gear_reg}, rise.gear_fwd,
      rise.gear_back, {1'b0, GEAR_LAST});
   always_ff @(posedge clk_sys) begin
      if (srst) gear_reg <= GEAR_RST;
      else if (gear_act) gear_reg <= gear_step[1:0];
   end

   // push-push pump and percussion
   logic pump_reg, perc_reg;
   always_ff @(posedge clk_sys) begin
      pump_reg <= (srst || !drill) ? 1'b0 : pump_reg ^ (drun && rise.pump);
      perc_reg <= (srst || !drill) ? 1'b0
                  : perc_reg ^ (drun && rise.perc);
   end

   // stick priorities, mode gating and slow scaling
   wire [7:0] blk = {2'b00, defl[6], defl[0] | defl[7], 4'h0};
   wire [7:0] hold = {au1_reg == AU_ON, au2_reg == AU_ON, 6'h00};
   wire slow = sw.key_slow && move;
   logic [NSTICK-1:0][STICK_W-1:0] stick_next;
   for (genvar i = 0; i < NSTICK; i++) begin : g_stk
      wire en = run && mode_mask[i] && !blk[i] && !hold[i];
      wire [7:0] v = (slow && SLOW_MASK[i]) ? {stick[i][7], stick[i][7:1]}
                                            : stick[i];
      assign stick_next[i] = en ? v : 8'h00;
   end
   wire pp_en = drun && !gear_act;
   wire push_n = pp_en && sw.push_pull_up;
   wire pull_n = pp_en && sw.push_pull_down;
   wire max_n = pull_n || defl[0];
   wire [7:0] force_n = !(push_n || pull_n) ? 8'h00
                        : max_n ? FORCE_MAX : knob_t;

   // registered outputs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stick_cmd <= '0;
         push_cmd <= 1'b0;
         pull_cmd <= 1'b0;
         force_cmd <= 8'h00;
         head_speed_max <= 1'b0;
         head1_speed_cmd <= 8'h00;
         battery_status_lamp <= '0;
         option_check_lamp <= 1'b0;
      end else begin
         stick_cmd <= stick_next;
         push_cmd <= push_n;
         pull_cmd <= pull_n;
         force_cmd <= force_n;
         head_speed_max <= (push_n || pull_n) && stick_next[0] != 8'h00;
         head1_speed_cmd <= (au1_reg == AU_ON && run) ? knob_h : 8'h00;
         battery_status_lamp.red <= st_next inside {LS_ORANGE, LS_ALARM,
                                                   LS_RED};
         battery_status_lamp.green <= st_next inside {LS_ORANGE, LS_ALARM,
            LS_GREEN} || (st_next == LS_LINK && phase_reg);
         option_check_lamp <= fault_reg && fast_ph_reg;
      end
   end
   assign link_active = link;
   assign head1_auto = au1_reg == AU_ON;
   assign head2_auto = au2_reg == AU_ON;
   assign head2_level = level_reg;
   assign pump_on = pump_reg;
   assign percussion_on = perc_reg;
   assign gear_output_a = run && gear_reg == 2'h1;
   assign gear_output_b = run && gear_reg == 2'h2;
   assign aux_a_cmd = run && !gear_act && sw.aux_a;
   assign aux_b_cmd = run && !gear_act && sw.aux_b;
   assign charger_block = gear_act;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_orange_end;
      st_reg == LS_ORANGE && tmr_done && sw.key_pos1;
   endsequence
   sequence s_green_start;
      st_reg == LS_GREEN && tmr_reg == LD_GREEN;
   endsequence
   property p_start_gate;
      (st_reg == LS_IDLE ##1 st_reg != LS_IDLE) |-> $past(start_ok);
   endproperty
   a_start_gate: assert property (p_start_gate)
      else $error("left idle without a valid start");
   property p_ok_seq;
      s_orange_end |=> s_green_start;
   endproperty
   a_ok_seq: assert property (p_ok_seq)
      else $error("orange did not hand over to green");
   property p_alarm_off;
      (st_reg == LS_ALARM && tmr_done && !btn.start && sw.key_pos1)
         |=> st_reg == LS_IDLE ##1 battery_status_lamp == 2'b00;
   endproperty
   a_alarm_off: assert property (p_alarm_off)
      else $error("alarm did not end in off");
   property p_j1_j5;
      !(stick_cmd[0] != 8'h00 && stick_cmd[4] != 8'h00);
   endproperty
   a_j1_j5: assert property (p_j1_j5)
      else $error("sticks 1 and 5 both driven");
   property p_j8_j5;
      (defl[7] && defl[4]) |=> stick_cmd[4] == 8'h00;
   endproperty
   a_j8_j5: assert property (p_j8_j5)
      else $error("stick 5 driven against stick 8");
   property p_j7_j6;
      (defl[6] && defl[5]) |=> stick_cmd[5] == 8'h00;
   endproperty
   a_j7_j6: assert property (p_j7_j6)
      else $error("stick 6 driven against stick 7");
   property p_fault_off;
      fault_reg |=> stick_cmd == '0 && !push_cmd && !pull_cmd;
   endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("outputs on during drill entry fault");
   property p_level_up;
      (init_reg && drun && rise.h2_up && !rise.h2_down)
         |=> level_reg == (($past(level_reg) == LEVEL_MAX) ? LEVEL_MAX
                           : $past(level_reg) + 3'h1);
   endproperty
   a_level_up: assert property (p_level_up)
      else $error("head 2 level step wrong");
   property p_pump_clear;
      !drill |=> !pump_on && !percussion_on;
   endproperty
   a_pump_clear: assert property (p_pump_clear)
      else $error("latched output kept outside drill");
   property p_h1_cancel;
      (au1_reg == AU_ON && defl[7]) |=> !head1_auto;
   endproperty
   a_h1_cancel: assert property (p_h1_cancel)
      else $error("head 1 auto not cancelled");
   property p_gear_excl;
      !(gear_output_a && gear_output_b);
   endproperty
   a_gear_excl: assert property (p_gear_excl)
      else $error("both gear outputs on");
endmodule
`default_nettype wire

// >>> sim/rtc_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none
// receiving unit: applies the command frame only while the link is up
module rtc_rx_model import rtc_pkg::*; (
   // clock and link
   input wire logic clk_sys,
   input wire logic link_active,
   // command frame from the handset
   input wire logic [NSTICK-1:0][STICK_W-1:0] stick_cmd,
   // drive applied to the valves
   output logic [NSTICK-1:0][STICK_W-1:0] valve_drive
);
   // a lost link must not leave a valve open, so drop at once
   always_ff @(posedge clk_sys) begin
      valve_drive <= link_active ? stick_cmd : '0;
   end
endmodule
`default_nettype wire

// >>> sim/test_rtc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtc_ctrl import rtc_pkg::*; ();
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   rtc_btn_t btn;
   rtc_sw_t sw;
   rtc_lamp_t lamp;
   logic [7:0][7:0] stk, stick_cmd, valve_drive;
   logic [7:0] knob1, knob2, head1_speed_cmd, force_cmd;
   logic [2:0] restore, head2_level, lvl;
   logic [1:0] step;
   logic link_active, option_check_lamp, head1_auto, head2_auto;
   logic push_cmd, pull_cmd, head_speed_max, pump_on, percussion_on;
   logic gear_output_a, gear_output_b, aux_a_cmd, aux_b_cmd, charger_block;
   int err_count = 0;
   int samples_checked = 0;
   int seed = 79126;
   int n;

   // short timing figures keep the run brief; the fast blink keeps its
   // full period, so the fault lamp holds steady for the whole run
   rtc_ctrl #(.T_ORANGE(5), .T_GREEN(10), .T_ALARM(10), .T_FLASH(5),
      .T_DEB(2)) rtc_ctrl_i (
      .clk_sys(clk_sys), .srst(srst), .btn_raw(btn), .sw_raw(sw),
      .stick_raw(stk), .thrust_force_knob(knob1),
      .head1_speed_knob(knob2), .head2_level_restore(restore),
      .link_active(link_active), .battery_status_lamp(lamp),
      .option_check_lamp(option_check_lamp), .stick_cmd(stick_cmd),
      .head1_auto(head1_auto), .head1_speed_cmd(head1_speed_cmd),
      .head2_auto(head2_auto), .head2_level(head2_level),
      .push_cmd(push_cmd), .pull_cmd(pull_cmd), .force_cmd(force_cmd),
      .head_speed_max(head_speed_max), .pump_on(pump_on),
      .percussion_on(percussion_on), .gear_output_a(gear_output_a),
      .gear_output_b(gear_output_b), .aux_a_cmd(aux_a_cmd),
      .aux_b_cmd(aux_b_cmd), .charger_block(charger_block));

   // far side of the radio link
   rtc_rx_model rtc_rx_model_i (.clk_sys(clk_sys),
      .link_active(link_active), .stick_cmd(stick_cmd),
      .valve_drive(valve_drive));

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   // inputs change 1 ns after the edge so sampling never races
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input string what, input logic [63:0] exp,
         input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // held long enough to pass sync and debounce, then released as long
   task automatic press(input logic [7:0] m);
      btn = rtc_btn_t'(btn | m);
      tick(8);
      btn = rtc_btn_t'(btn & ~m);
      tick(8);
   endtask

   task automatic mode(input logic [2:0] m);
      sw.mode_selector = m;
      tick(6);
   endtask

   // counts cycles the lamp holds one colour, bounded
   task automatic run_len(input logic [1:0] v, output int k);
      k = 0;
      while (lamp === v && k < 40) begin
         tick(1);
         k++;
      end
   endtask

   task automatic wait_lamp(input logic [1:0] v);
      int k;
      k = 0;
      while (lamp !== v && k < 40) begin
         tick(1);
         k++;
      end
   endtask

   // mask by mode, then priorities on raw deflection, then slow halving
   function automatic logic [63:0] exp_sticks(input logic [2:0] md,
         input logic slow, input logic [7:0][7:0] s);
      logic [7:0] m;
      logic [7:0][7:0] r;
      m = (md == MODE_MOVE) ? MOVE_MASK_DEF :
         (md == MODE_PLACE) ? PLACE_MASK_DEF : DRILL_MASK_DEF;
      for (int i = 0; i < 8; i++) begin
         r[i] = m[i] ? s[i] : 8'h00;
      end
      if (s[0] != 8'h00 || s[7] != 8'h00) r[4] = 8'h00;
      if (s[6] != 8'h00) r[5] = 8'h00;
      if (slow && md == MODE_MOVE) begin
         for (int i = 0; i < 8; i++) begin
            if (i inside {1, 2, 3, 6}) r[i] = $signed(r[i]) >>> 1;
         end
      end
      return r;
   endfunction

   // random sticks, half of them at rest, limited to the allowed set; the first pass puts 0x80 on sticks 1-7 in every mode
   task automatic stick_run(input logic [2:0] md, input logic [7:0] keep,
         input int reps);
      for (int j = 0; j < reps; j++) begin
         for (int i = 0; i < 8; i++) begin
            stk[i] = ($random(seed) & 1) && keep[i] ? 8'($random(seed)) : 8'h00;
         end
         if (j == 0) stk = {8{8'h80}} & {{8{keep[7]}}, {56{1'b1}}};
         tick(6);
         chk("stick_cmd", exp_sticks(md, sw.key_slow, stk), stick_cmd);
         chk("valve_drive", exp_sticks(md, sw.key_slow, stk),
            valve_drive);
      end
      stk = '0;
      tick(6);
   endtask

   task automatic auto_latch(input int idx);
      stk[idx] = 8'h40;
      tick(6);
      btn.auto_rot = 1'b1;
      tick(8);
      stk[idx] = 8'h00;
      tick(8);
      btn.auto_rot = 1'b0;
      tick(8);
   endtask

   // watchdog well beyond the expected run length
   initial begin
      tick(30000);
      err_count++;
      stop_test();
   end

   initial begin
      btn = '0;
      sw = '0;
      stk = '0;
      knob1 = 8'($random(seed));
      knob2 = 8'($random(seed));
      restore = 3'($random(seed));
      sw.mode_selector = MODE_PLACE;
      tick(16);
      srst = 1'b0;
      tick(4);
      chk("head2_level", restore, head2_level);
      press(8'h80);
      chk("no key start", 0, {lamp, link_active});
      sw.key_pos1 = 1'b1;
      stk[2] = 8'h30;
      btn.start = 1'b1;
      // count from the first orange cycle, release well before it ends
      wait_lamp(2'b11);
      btn.start = 1'b0;
      run_len(2'b11, n);
      chk("alarm orange", 10, n);
      chk("alarm off", 0, {lamp, link_active});
      stk[2] = 8'h00;
      sw.estop = 1'b1;
      tick(6);
      btn.start = 1'b1;
      wait_lamp(2'b11);
      run_len(2'b11, n);
      chk("alarm red", 2'b10, lamp);
      sw.estop = 1'b0;
      tick(6);
      chk("red clears", 0, {lamp, link_active});
      btn.start = 1'b0;
      tick(8);
      btn.start = 1'b1;
      wait_lamp(2'b11);
      run_len(2'b11, n);
      chk("start orange", 5, n);
      btn.start = 1'b0;
      n = 0;
      while (link_active !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk("start green", 10, n);
      wait_lamp(2'b00);
      run_len(2'b00, n);
      chk("flash half", 5, n);
      chk("flash on", 2'b01, lamp);
      stick_run(MODE_PLACE, 8'h3F, 8);
      sw.key_slow = 1'b1;
      mode(MODE_MOVE);
      stick_run(MODE_MOVE, 8'hFF, 8);
      mode(MODE_DRILL);
      stick_run(MODE_DRILL, 8'hFF, 16);
      sw.push_pull_up = 1'b1;
      tick(6);
      chk("push", {3'b100, knob1}, {push_cmd, pull_cmd, head_speed_max,
         force_cmd});
      sw.push_pull_up = 1'b0;
      sw.push_pull_down = 1'b1;
      tick(6);
      chk("pull", {3'b010, FORCE_MAX}, {push_cmd, pull_cmd, head_speed_max,
         force_cmd});
      stk[0] = 8'h20;
      tick(6);
      chk("rapid", {3'b011, FORCE_MAX}, {push_cmd, pull_cmd, head_speed_max,
         force_cmd});
      mode(MODE_PLACE);
      mode(MODE_DRILL);
      n = 0;
      while (option_check_lamp !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      chk("fault lamp", 1, option_check_lamp);
      chk("fault off", 0, stick_cmd);
      chk("fault pull", 0, pull_cmd);
      sw.push_pull_down = 1'b0;
      tick(6);
      chk("fault gone", exp_sticks(MODE_DRILL, 1'b1, stk), stick_cmd);
      stk = '0;
      press(8'h02);
      chk("pump on", 1, pump_on);
      press(8'h02);
      chk("pump off", 0, pump_on);
      press(8'h03);
      chk("both on", 2'b11, {pump_on, percussion_on});
      mode(MODE_PLACE);
      chk("leave drill", 0, {pump_on, percussion_on});
      mode(MODE_DRILL);
      sw.gear_enable = 1'b1;
      sw.aux_a = 1'b1;
      sw.aux_b = 1'b1;
      tick(6);
      chk("gear blocks", 3'b100, {charger_block, aux_a_cmd,
         aux_b_cmd});
      step = 2'h0;
      for (int i = 0; i < 6; i++) begin
         press(i < 3 ? 8'h08 : 8'h04);
         if (i < 3) step = (step == 2'h2) ? 2'h2 : step + 2'h1;
         else step = (step == 2'h0) ? 2'h0 : step - 2'h1;
         chk("gear", {step == 2'h1, step == 2'h2},
            {gear_output_a, gear_output_b});
      end
      sw.gear_enable = 1'b0;
      tick(6);
      chk("aux free", 2'b11, {aux_a_cmd, aux_b_cmd});
      sw.aux_a = 1'b0;
      sw.aux_b = 1'b0;
      lvl = restore;
      btn.h2_up = 1'b1;
      tick(1);
      btn.h2_up = 1'b0;
      tick(8);
      chk("glitch", lvl, head2_level);
      for (int i = 0; i < 18; i++) begin
         press(i < 9 ? 8'h20 : 8'h10);
         if (i < 9) lvl = (lvl == LEVEL_MAX) ? LEVEL_MAX : lvl + 3'h1;
         else lvl = (lvl == 3'h0) ? 3'h0 : lvl - 3'h1;
         chk("head2_level", lvl, head2_level);
      end
      auto_latch(7);
      chk("head1 auto", {1'b1, knob2}, {head1_auto, head1_speed_cmd});
      stk[7] = 8'h10;
      tick(6);
      chk("head1 cancel", 0, head1_auto);
      stk[7] = 8'h00;
      tick(6);
      auto_latch(6);
      chk("head2 auto", 1, head2_auto);
      stk[6] = 8'hF0;
      tick(6);
      chk("head2 cancel", 0, head2_auto);
      stk[6] = 8'h00;
      tick(6);
      auto_latch(7);
      auto_latch(6);
      mode(MODE_PLACE);
      chk("autos drop", 0, {head1_auto, head2_auto});
      stk[0] = 8'h22;
      sw.key_pos1 = 1'b0;
      tick(6);
      chk("link down", 0, link_active);
      chk("valves shut", 0, valve_drive);
      stop_test();
   end
endmodule
`default_nettype wire
